// ### ela_cfg.svh
// register offsets, field positions and reset values for the alarm control block
`ifndef ELA_CFG_SVH
`define ELA_CFG_SVH
`define ELA_OFS_TEMP_LO 10'h208
`define ELA_OFS_TEMP_HI 10'h209
`define ELA_OFS_HUM_LO 10'h20a
`define ELA_OFS_HUM_HI 10'h20b
`define ELA_OFS_HRES_LO 10'h20e
`define ELA_OFS_HRES_HI 10'h20f
`define ELA_OFS_TCTRL 10'h210
`define ELA_OFS_HCTRL 10'h211
`define ELA_OFS_CLKCTRL 10'h212
`define ELA_OFS_MCTRL 10'h213
`define ELA_OFS_ASTAT 10'h214
`define ELA_BIT_LOW_EN 0
`define ELA_BIT_HIGH_EN 1
`define ELA_BIT_OSC_EN 0
`define ELA_BIT_SAMPLE_SEC 1
`define ELA_BIT_HUM_LOG_EN 1
`define ELA_BIT_HUM_FMT 3
`define ELA_BIT_TLF 0
`define ELA_BIT_THF 1
`define ELA_BIT_HLF 2
`define ELA_BIT_HHF 3
`define ELA_RST_THRESH 8'h00
`define ELA_RST_CTRL 2'h0
`define ELA_RST_MCTRL 8'hc0
`define ELA_MCTRL_ONES 8'hc0
`define ELA_TCTRL_PAD 6'h00
`define ELA_HCTRL_PAD 6'h3f
`define ELA_CLK_PAD 6'h00
`define ELA_ASTAT_PAD 3'h7
`endif

// ### ela_pkg.sv
// types shared by the alarm control block
package ela_pkg;
    typedef logic [7:0] ela_byte_t;
    typedef logic [9:0] ela_addr_t;
    typedef enum logic [1:0] {ELA_IDLE = 2'b00, ELA_TEMP = 2'b01, ELA_HUM = 2'b11} ela_cmp_e;
endpackage : ela_pkg

// ### ela_cmp.sv
// unsigned threshold comparator with enables
`timescale 1ns/10ps
module ela_cmp
(
    input wire logic [7:0] sample,
    input wire logic [7:0] low_thresh,
    input wire logic [7:0] high_thresh,
    input wire logic low_en,
    input wire logic high_en,
    output logic hit_low,
    output logic hit_high
);
    // unsigned compare, inclusive at the threshold
    assign hit_low = low_en && (sample <= low_thresh);
    assign hit_high = high_en && (sample >= high_thresh);
endmodule : ela_cmp

// ### ela_alarm_ctrl.sv
// register page and alarm logic of the environment logger
//
// Overview of operation
// - in a mission with humidity logging, log high byte always, low byte in 16-bit format.
// - latest humidity result: bits 11..4 at 20f, bits 3..0 upper nibble of 20e.
// - mission control bit at 213 selects 8-bit (0) or 16-bit (1) humidity logging.
// - humidity alarm compare uses only the result's most significant byte.
// - humidity thresholds compare against raw uncorrected sensor readings.
// - humidity low threshold at 20a, high threshold at 20b, one byte each.
// - temperature low threshold at 208, high threshold at 209, one byte each.
// - 210 holds temp high enable bit 1, low enable bit 0; others read zero.
// - 211 holds humidity high enable bit 1, low enable bit 0; others read one.
// - during a mission the three control registers ignore writes.
// - enabled temp high alarm sets its flag when reading is at or above threshold.
// - enabled temp low alarm sets its flag when reading is at or below threshold.
// - enabled humidity high alarm sets its flag when at or above threshold.
// - enabled humidity low alarm sets its flag when at or below threshold.
// - alarm flags are readable in the alarm status register at 214.
// - sample unit bit selects minutes when zero and seconds when one.
// - oscillator enable one runs the oscillator; zero stops it for data retention.
// - forced conversion or start mission sets the oscillator enable.
// - 212 holds oscillator enable bit 0 and sample unit bit 1; rest read zero.
// - humidity logging in a mission only when mission control bit 1 is set.
// - clear memory clears all alarm flags together; status is otherwise read-only.
`timescale 1ns/10ps
`include "ela_cfg.svh"
module ela_alarm_ctrl
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [9:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output ela_pkg::ela_byte_t reg_rdata,
    input wire logic mission_active,
    input wire logic mission_mctrl_wr,
    input wire logic cmd_force_conv,
    input wire logic cmd_start_mission,
    input wire logic cmd_clear_memory,
    input wire logic temp_valid,
    input wire logic [7:0] temp_msb,
    input wire logic hum_valid,
    input wire logic [15:0] hum_raw,
    output logic log_wr,
    output logic [7:0] log_data,
    output logic oscillator_enable,
    output logic sample_unit_seconds,
    output logic [3:0] alarm_flags
);
    import ela_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers
    ela_byte_t temp_lo_reg, temp_hi_reg, hum_lo_reg, hum_hi_reg;
    ela_byte_t hres_lo_reg, hres_hi_reg;
    logic [1:0] tctrl_reg, hctrl_reg, clkctrl_reg;
    logic [1:0] clkctrl_next;
    ela_byte_t mctrl_reg;
    logic [3:0] flags_reg, flags_next;
    ela_byte_t rdata_next;
    logic low_pending_reg;
    ela_byte_t pending_byte_reg;
    logic log_wr_next;
    ela_byte_t log_data_next;
    logic low_pending_next;
    ela_cmp_e cmp_state_reg, cmp_state_next;

    // strobe passed in, so the decode wires re-evaluate when it drops with the address held
    function automatic logic wr_hit(input logic we, input ela_addr_t a, input ela_addr_t ofs);
        wr_hit = we && (a == ofs);
    endfunction : wr_hit

    ////////////////////////////////////////////////////////////////////////
    // write decode
    wire ctrl_open = !mission_active;
    wire w_temp_lo = wr_hit(reg_wr, reg_addr, `ELA_OFS_TEMP_LO);
    wire w_temp_hi = wr_hit(reg_wr, reg_addr, `ELA_OFS_TEMP_HI);
    wire w_hum_lo = wr_hit(reg_wr, reg_addr, `ELA_OFS_HUM_LO);
    wire w_hum_hi = wr_hit(reg_wr, reg_addr, `ELA_OFS_HUM_HI);
    wire w_tctrl = wr_hit(reg_wr, reg_addr, `ELA_OFS_TCTRL) && ctrl_open;
    wire w_hctrl = wr_hit(reg_wr, reg_addr, `ELA_OFS_HCTRL) && ctrl_open;
    wire w_clk = wr_hit(reg_wr, reg_addr, `ELA_OFS_CLKCTRL) && ctrl_open;
    // mission control may be loaded by the host only between missions; the mission controller strobe loads it at any time
    wire w_mctrl = wr_hit(reg_wr, reg_addr, `ELA_OFS_MCTRL) && ctrl_open;

    // a command forcing the oscillator on beats a simultaneous write of zero
    wire osc_force = cmd_force_conv || cmd_start_mission;
    wire [1:0] clk_wr_val = w_clk ? reg_wdata[1:0] : clkctrl_reg;
    assign clkctrl_next = {clk_wr_val[`ELA_BIT_SAMPLE_SEC], clk_wr_val[`ELA_BIT_OSC_EN] | osc_force};

    ////////////////////////////////////////////////////////////////////////
    // compare path
    wire hum_fmt16 = mctrl_reg[`ELA_BIT_HUM_FMT];
    wire hum_log_en = mctrl_reg[`ELA_BIT_HUM_LOG_EN];
    wire [7:0] hum_msb = hum_raw[15:8];
    wire t_lo, t_hi, h_lo, h_hi;
    wire [7:0] cmp_sample = temp_valid ? temp_msb : hum_msb;
    wire [7:0] cmp_lo = temp_valid ? temp_lo_reg : hum_lo_reg;
    wire [7:0] cmp_hi = temp_valid ? temp_hi_reg : hum_hi_reg;
    wire cmp_lo_en = temp_valid ? tctrl_reg[`ELA_BIT_LOW_EN] : hctrl_reg[`ELA_BIT_LOW_EN];
    wire cmp_hi_en = temp_valid ? tctrl_reg[`ELA_BIT_HIGH_EN] : hctrl_reg[`ELA_BIT_HIGH_EN];
    wire cmp_hit_lo, cmp_hit_hi;

    // one comparator shared; temperature and humidity results are taken in separate cycles
    ela_cmp u_cmp
    (
        .sample(cmp_sample),
        .low_thresh(cmp_lo),
        .high_thresh(cmp_hi),
        .low_en(cmp_lo_en),
        .high_en(cmp_hi_en),
        .hit_low(cmp_hit_lo),
        .hit_high(cmp_hit_hi)
    );

    assign cmp_state_next = temp_valid ? ELA_TEMP : (hum_valid ? ELA_HUM : ELA_IDLE);
    wire in_mission = mission_active;
    assign t_lo = in_mission && temp_valid && cmp_hit_lo;
    assign t_hi = in_mission && temp_valid && cmp_hit_hi;
    // humidity that coincides with temperature is dropped; source must space them
    assign h_lo = in_mission && hum_valid && !temp_valid && cmp_hit_lo;
    assign h_hi = in_mission && hum_valid && !temp_valid && cmp_hit_hi;

    wire [3:0] flag_set = {h_hi, h_lo, t_hi, t_lo};
    // a new alarm in the clear cycle survives the clear
    assign flags_next = (cmd_clear_memory ? 4'h0 : flags_reg) | flag_set;

    ////////////////////////////////////////////////////////////////////////
    // humidity logging: high byte first, low byte one cycle later in 16-bit format
    wire hum_log_now = in_mission && hum_log_en && hum_valid && !temp_valid;
    always_comb
    begin
        log_wr_next = 1'b0;
        log_data_next = 8'h00;
        low_pending_next = 1'b0;
        if (hum_log_now)
        begin
            log_wr_next = 1'b1;
            log_data_next = hum_raw[15:8];
            low_pending_next = hum_fmt16;
        end
        else if (low_pending_reg)
        begin
            log_wr_next = 1'b1;
            log_data_next = pending_byte_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux
    wire [7:0] tctrl_rd = {`ELA_TCTRL_PAD, tctrl_reg};
    wire [7:0] hctrl_rd = {`ELA_HCTRL_PAD, hctrl_reg};
    wire [7:0] clk_rd = {`ELA_CLK_PAD, clkctrl_reg};
    wire [7:0] astat_rd = {1'b0, `ELA_ASTAT_PAD, flags_reg};
    always_comb
    begin
        unique case (reg_addr)
            `ELA_OFS_TEMP_LO: rdata_next = temp_lo_reg;
            `ELA_OFS_TEMP_HI: rdata_next = temp_hi_reg;
            `ELA_OFS_HUM_LO: rdata_next = hum_lo_reg;
            `ELA_OFS_HUM_HI: rdata_next = hum_hi_reg;
            `ELA_OFS_HRES_LO: rdata_next = hres_lo_reg;
            `ELA_OFS_HRES_HI: rdata_next = hres_hi_reg;
            `ELA_OFS_TCTRL: rdata_next = tctrl_rd;
            `ELA_OFS_HCTRL: rdata_next = hctrl_rd;
            `ELA_OFS_CLKCTRL: rdata_next = clk_rd;
            `ELA_OFS_MCTRL: rdata_next = mctrl_reg;
            `ELA_OFS_ASTAT: rdata_next = astat_rd;
            default: rdata_next = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            temp_lo_reg <= `ELA_RST_THRESH;
            temp_hi_reg <= `ELA_RST_THRESH;
            hum_lo_reg <= `ELA_RST_THRESH;
            hum_hi_reg <= `ELA_RST_THRESH;
        end
        else
        begin
            if (w_temp_lo) temp_lo_reg <= reg_wdata;
            if (w_temp_hi) temp_hi_reg <= reg_wdata;
            if (w_hum_lo) hum_lo_reg <= reg_wdata;
            if (w_hum_hi) hum_hi_reg <= reg_wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tctrl_reg <= `ELA_RST_CTRL;
            hctrl_reg <= `ELA_RST_CTRL;
            clkctrl_reg <= `ELA_RST_CTRL;
            mctrl_reg <= `ELA_RST_MCTRL;
        end
        else
        begin
            if (w_tctrl) tctrl_reg <= reg_wdata[1:0];
            if (w_hctrl) hctrl_reg <= reg_wdata[1:0];
            clkctrl_reg <= clkctrl_next;
            if (w_mctrl || mission_mctrl_wr) mctrl_reg <= reg_wdata | `ELA_MCTRL_ONES;
        end
    end

    // the sensor always delivers 16 bits; the low nibble is passed through as undefined
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hres_lo_reg <= 8'h00;
            hres_hi_reg <= 8'h00;
            pending_byte_reg <= 8'h00;
        end
        else if (hum_valid && !temp_valid)
        begin
            hres_hi_reg <= hum_raw[15:8];
            hres_lo_reg <= hum_raw[7:0];
            pending_byte_reg <= hum_raw[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            flags_reg <= 4'h0;
            reg_rdata <= 8'h00;
            log_wr <= 1'b0;
            log_data <= 8'h00;
            low_pending_reg <= 1'b0;
            cmp_state_reg <= ELA_IDLE;
            oscillator_enable <= 1'b0;
            sample_unit_seconds <= 1'b0;
            alarm_flags <= 4'h0;
        end
        else
        begin
            flags_reg <= flags_next;
            reg_rdata <= rdata_next;
            log_wr <= log_wr_next;
            log_data <= log_data_next;
            low_pending_reg <= low_pending_next;
            cmp_state_reg <= cmp_state_next;
            oscillator_enable <= clkctrl_next[`ELA_BIT_OSC_EN];
            sample_unit_seconds <= clkctrl_next[`ELA_BIT_SAMPLE_SEC];
            alarm_flags <= flags_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    a_temp_high_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mission_active && temp_valid && tctrl_reg[1] && temp_msb >= temp_hi_reg) |=> flags_reg[1])
        else $error("temp high flag not set");
    a_temp_low_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mission_active && temp_valid && tctrl_reg[0] && temp_msb <= temp_lo_reg) |=> flags_reg[0])
        else $error("temp low flag not set");
    a_temp_high_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!tctrl_reg[1] && !flags_reg[1] && !cmd_clear_memory) |=> !flags_reg[1])
        else $error("temp high flag set while disabled");
    a_hum_high_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mission_active && hum_valid && !temp_valid && hctrl_reg[1] && hum_raw[15:8] >= hum_hi_reg)
        |=> flags_reg[3])
        else $error("humidity high flag not set");
    a_hum_low_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mission_active && hum_valid && !temp_valid && hctrl_reg[0] && hum_raw[15:8] <= hum_lo_reg)
        |=> flags_reg[2])
        else $error("humidity low flag not set");
    a_flags_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|flags_reg && !cmd_clear_memory) |=> ((flags_reg & $past(flags_reg)) == $past(flags_reg)))
        else $error("alarm flag dropped without clear");
    a_clear_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cmd_clear_memory && !mission_active) |=> (flags_reg == 4'h0))
        else $error("clear memory left a flag");
    a_ctrl_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mission_active |=> ($stable(tctrl_reg) && $stable(hctrl_reg)))
        else $error("control register changed in mission");
    a_osc_forced: assert property (@(posedge ref_clk) disable iff (!rst_n)
        osc_force |=> (oscillator_enable && clkctrl_reg[0]))
        else $error("oscillator not started by command");
    a_log_low_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hum_log_now && hum_fmt16) |=> log_wr ##1 (log_wr && log_data == $past(hum_raw[7:0], 2)))
        else $error("low humidity byte not logged");
    a_log_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!hum_log_en && !low_pending_reg) |=> !log_wr)
        else $error("humidity logged while disabled");

    // flags rise only with a sample of their own kind, and only in a mission
    a_set_in_mission: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !mission_active |=> ((flags_reg & ~$past(flags_reg)) == 4'h0))
        else $error("alarm flag set outside a mission");
    a_temp_low_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!tctrl_reg[0] && !flags_reg[0]) |=> !flags_reg[0])
        else $error("temp low flag set while disabled");
    a_hum_high_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!hctrl_reg[1] && !flags_reg[3]) |=> !flags_reg[3])
        else $error("humidity high flag set while disabled");
    a_hum_low_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!hctrl_reg[0] && !flags_reg[2]) |=> !flags_reg[2])
        else $error("humidity low flag set while disabled");
    a_idle_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cmp_state_reg == ELA_IDLE && !$past(cmd_clear_memory)) |-> (flags_reg == $past(flags_reg)))
        else $error("alarm flags changed with no sample");
    a_temp_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cmp_state_reg == ELA_TEMP && !$past(cmd_clear_memory)) |-> (flags_reg[3:2] == $past(flags_reg[3:2])))
        else $error("humidity flag moved on a temperature sample");
    a_hum_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cmp_state_reg == ELA_HUM && !$past(cmd_clear_memory)) |-> (flags_reg[1:0] == $past(flags_reg[1:0])))
        else $error("temp flag moved on a humidity sample");

    // register, capture and logging paths
    a_thresh_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !reg_wr |=> ($stable(temp_lo_reg) && $stable(temp_hi_reg)
            && $stable(hum_lo_reg) && $stable(hum_hi_reg)))
        else $error("threshold changed without a write");
    a_temp_lo_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        w_temp_lo |=> (temp_lo_reg == $past(reg_wdata)))
        else $error("temp low threshold write lost");
    a_hum_hi_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        w_hum_hi |=> (hum_hi_reg == $past(reg_wdata)))
        else $error("humidity high threshold write lost");
    a_tctrl_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        w_tctrl |=> (tctrl_reg == $past(reg_wdata[1:0])))
        else $error("temp enable write lost");
    a_hctrl_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        w_hctrl |=> (hctrl_reg == $past(reg_wdata[1:0])))
        else $error("humidity enable write lost");
    a_osc_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (w_clk && !osc_force) |=> (clkctrl_reg == $past(reg_wdata[1:0])))
        else $error("clock control write lost");
    a_clk_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mission_active && !osc_force) |=> $stable(clkctrl_reg))
        else $error("clock control changed in mission");
    a_status_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (reg_addr == `ELA_OFS_ASTAT) |=> (reg_rdata == {4'h7, $past(flags_reg)}))
        else $error("alarm status read wrong");
    a_hres_capture: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (hum_valid && !temp_valid) |=> (hres_hi_reg == $past(hum_raw[15:8]) && hres_lo_reg == $past(hum_raw[7:0])))
        else $error("humidity result not captured");
    a_log_high_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hum_log_now |=> (log_wr && log_data == $past(hum_raw[15:8])))
        else $error("high humidity byte not logged");
    a_log_one_byte: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((hum_log_now && !hum_fmt16) ##1 !hum_valid) |=> !log_wr)
        else $error("extra byte logged in 8-bit format");
endmodule : ela_alarm_ctrl

// ### ela_host.sv
// host-side register master model for the alarm control block
`timescale 1ns/10ps
module ela_host
(
    input wire logic ref_clk,
    output logic [9:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial
    begin
        reg_addr = 10'h3ff;
        reg_wr = 1'b0;
        reg_wdata = 8'h00;
    end
    ////////////////////////////////////////////////////////////
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr = 1'b0;
        // released data must not keep showing the byte
        reg_wdata = ~d;
    endtask : wr
    // registered read data: hold the address across one edge
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        @(posedge ref_clk);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : ela_host

// ### test_env_logger_alarm_control.sv
// self-checking bench for the logger alarm control block
`timescale 1ns/10ps
module test_env_logger_alarm_control;
    import ela_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic mission_active = 1'b0;
    logic mission_mctrl_wr = 1'b0;
    logic cmd_force_conv = 1'b0;
    logic cmd_start_mission = 1'b0;
    logic cmd_clear_memory = 1'b0;
    logic temp_valid = 1'b0;
    logic [7:0] temp_msb = 8'h00;
    logic hum_valid = 1'b0;
    logic [15:0] hum_raw = 16'h0000;
    logic [9:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    ela_byte_t reg_rdata;
    logic log_wr;
    logic [7:0] log_data;
    logic oscillator_enable;
    logic sample_unit_seconds;
    logic [3:0] alarm_flags;
    logic [7:0] rb;
    logic [9:0] ra[8] = '{10'h208, 10'h209, 10'h20a, 10'h20b, 10'h210, 10'h211, 10'h212, 10'h214};
    int error_cnt = 0;
    int samples_checked = 0;
    ela_alarm_ctrl DUT
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .mission_active(mission_active), .mission_mctrl_wr(mission_mctrl_wr),
        .cmd_force_conv(cmd_force_conv), .cmd_start_mission(cmd_start_mission), .cmd_clear_memory(cmd_clear_memory),
        .temp_valid(temp_valid), .temp_msb(temp_msb), .hum_valid(hum_valid), .hum_raw(hum_raw), .log_wr(log_wr),
        .log_data(log_data), .oscillator_enable(oscillator_enable), .sample_unit_seconds(sample_unit_seconds),
        .alarm_flags(alarm_flags)
    );
    ela_host host
    (
        .ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
    );
    always #2.5 ref_clk = ~ref_clk;
    ////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rchk(input logic [9:0] a, input logic [7:0] e);
        host.rd(a, rb);
        chk($sformatf("register %h", a), e, rb);
    endtask : rchk
    task automatic fchk(input logic [3:0] e);
        chk("alarm_flags", {4'h0, e}, {4'h0, alarm_flags});
    endtask : fchk
    task automatic ochk(input logic e);
        @(posedge ref_clk);
        #1;
        chk("oscillator_enable", {7'h0, e}, {7'h0, oscillator_enable});
    endtask : ochk
    task automatic pulse(ref logic s);
        @(posedge ref_clk);
        #1;
        s = 1'b1;
        @(posedge ref_clk);
        #1;
        s = 1'b0;
    endtask : pulse
    // value and strobe rise in one step, so back-to-back calls never reassign a signal
    task automatic temp_in(input logic [7:0] v);
        @(posedge ref_clk);
        #1;
        temp_msb = v;
        temp_valid = 1'b1;
        @(posedge ref_clk);
        #1;
        temp_valid = 1'b0;
        temp_msb = ~v;
    endtask : temp_in
    // lg: a log byte expected next cycle; wide: low byte follows it
    task automatic hum_in(input logic [15:0] v, input logic lg, input logic wide);
        hum_raw = v;
        pulse(hum_valid);
        hum_raw = ~v;
        chk("log_wr", {7'h0, lg}, {7'h0, log_wr});
        if (lg)
            chk("log_data high", v[15:8], log_data);
        @(posedge ref_clk);
        #1;
        chk("log_wr second", {7'h0, wide}, {7'h0, log_wr});
        if (wide)
            chk("log_data low", v[7:0], log_data);
    endtask : hum_in
    ////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [7:0] e[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hfc, 8'h00, 8'h70};
        fchk(4'h0);
        for (int i = 0; i < 8; i++)
            rchk(ra[i], e[i]);
        rchk(10'h215, 8'h00);
        rchk(10'h213, 8'hc0);
    endtask : t_reset
    task automatic t_regs;
        logic [7:0] d[8] = '{8'h11, 8'he2, 8'h5a, 8'h96, 8'hff, 8'h00, 8'hff, 8'h00};
        logic [7:0] e[8] = '{8'h11, 8'he2, 8'h5a, 8'h96, 8'h03, 8'hfc, 8'h03, 8'h70};
        for (int i = 0; i < 8; i++)
            host.wr(ra[i], d[i]);
        for (int i = 0; i < 8; i++)
            rchk(ra[i], e[i]);
        chk("sample_unit_seconds", 8'h01, {7'h0, sample_unit_seconds});
        host.wr(10'h212, 8'h01);
        ochk(1'b1);
        chk("sample_unit_seconds", 8'h00, {7'h0, sample_unit_seconds});
    endtask : t_regs
    task automatic t_lock;
        mission_active = 1'b1;
        host.wr(10'h210, 8'h00);
        host.wr(10'h211, 8'hff);
        host.wr(10'h212, 8'h02);
        rchk(10'h210, 8'h03);
        rchk(10'h211, 8'hfc);
        rchk(10'h212, 8'h01);
        mission_active = 1'b0;
    endtask : t_lock
    task automatic t_temp;
        host.wr(10'h208, 8'h40);
        host.wr(10'h209, 8'h80);
        temp_in(8'h80);
        fchk(4'h0);
        mission_active = 1'b1;
        temp_in(8'h80);
        fchk(4'h2);
        pulse(cmd_clear_memory);
        fchk(4'h0);
        temp_in(8'h41);
        temp_in(8'h7f);
        fchk(4'h0);
        temp_in(8'h40);
        fchk(4'h1);
        pulse(cmd_clear_memory);
        temp_in(8'hff);
        fchk(4'h2);
        temp_in(8'h00);
        fchk(4'h3);
        host.wr(10'h214, 8'h00);
        rchk(10'h214, 8'h73);
        pulse(cmd_clear_memory);
        mission_active = 1'b0;
        host.wr(10'h210, 8'h02);
        mission_active = 1'b1;
        temp_in(8'h00);
        fchk(4'h0);
        mission_active = 1'b0;
        host.wr(10'h210, 8'h01);
        mission_active = 1'b1;
        temp_in(8'hff);
        fchk(4'h0);
        mission_active = 1'b0;
    endtask : t_temp
    task automatic t_hum;
        host.wr(10'h20a, 8'h58);
        host.wr(10'h20b, 8'h97);
        host.wr(10'h211, 8'h03);
        host.wr(10'h213, 8'h02);
        rchk(10'h213, 8'hc2);
        mission_active = 1'b1;
        hum_in(16'h9730, 1'b1, 1'b0);
        fchk(4'h8);
        rchk(10'h20f, 8'h97);
        rchk(10'h20e, 8'h30);
        pulse(cmd_clear_memory);
        hum_in(16'h58f0, 1'b1, 1'b0);
        fchk(4'h4);
        host.reg_wdata = 8'h0a;
        pulse(mission_mctrl_wr);
        rchk(10'h213, 8'hca);
        hum_in(16'h5aa0, 1'b1, 1'b1);
        fchk(4'h4);
        host.reg_wdata = 8'h08;
        pulse(mission_mctrl_wr);
        hum_in(16'h9700, 1'b0, 1'b0);
        fchk(4'hc);
        mission_active = 1'b0;
        pulse(cmd_clear_memory);
        host.wr(10'h211, 8'h00);
        mission_active = 1'b1;
        hum_in(16'hff00, 1'b0, 1'b0);
        hum_in(16'h0000, 1'b0, 1'b0);
        fchk(4'h0);
        mission_active = 1'b0;
    endtask : t_hum
    task automatic t_osc;
        host.wr(10'h212, 8'h00);
        ochk(1'b0);
        pulse(cmd_force_conv);
        ochk(1'b1);
        host.wr(10'h212, 8'h00);
        ochk(1'b0);
        pulse(cmd_start_mission);
        ochk(1'b1);
        rchk(10'h212, 8'h01);
        // forcing command and a write of zero in one cycle: the command wins
        fork
            host.wr(10'h212, 8'h00);
            pulse(cmd_force_conv);
        join
        ochk(1'b1);
    endtask : t_osc
    task automatic results;
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    ////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_regs();
        t_lock();
        t_temp();
        t_hum();
        t_osc();
        results();
    end
    // the whole sequence needs well under a thousand cycles
    initial
    begin
        #50000;
        error_cnt++;
        results();
    end
endmodule : test_env_logger_alarm_control
